// *** verilog/ext_bus_ctrl.v ***
// external bus pin control: region waits, pin function select, bus cycles
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_ctrl_defines.vh"

// Notes on behaviour
// RULE1 - io region wait code gives 0-3 cycles
// RULE2 - high region wait, resets to three cycles
// RULE3 - low region wait, resets to zero
// RULE4 - address pin select: 0 address, 1 port
// RULE5 - address pin select clears on reset
// RULE6 - single chip blocks writes, all pins ports
// RULE7 - select registers write only, read ones
// RULE8 - clock output enable drives machine clock out
// RULE9 - ready enable accepts external ready input
// RULE10 - hold enable activates request and acknowledge
// RULE11 - io region bus size bit 16/8
// RULE12 - high region size resets from vector mode
// RULE13 - write strobe enable clear keeps ports
// RULE14 - unselected function pins act as ports
// RULE15 - 16-bit mode: two write strobes, read, latch
// RULE16 - strobe enable drives one or two strobes
// RULE17 - 8-bit mode upper strobe stays port
// RULE18 - low region bus size bit 16/8
// RULE19 - ready low stretches access with waits
// RULE20 - decode region, load wait counter first
module ext_bus_ctrl #(
  parameter ADDR_W = 24,
  parameter DATA_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // mode straps
  input wire single_chip_i,
  input wire bus16_i,
  input wire ext_vec_mode2_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // core access port
  input wire acc_req_i,
  input wire acc_write_i,
  input wire [ADDR_W-1:0] acc_addr_i,
  input wire [DATA_W-1:0] acc_wdata_i,
  output wire acc_ready_o,
  output reg acc_done_o,
  output reg [DATA_W-1:0] acc_rdata_o,
  output reg acc_width8_o,
  // external bus pins
  output reg [ADDR_W-1:0] addr_o,
  output reg addr_oe_o,
  output reg [DATA_W-1:0] data_o,
  output reg data_oe_o,
  input wire [DATA_W-1:0] data_i,
  output reg ale_o,
  output reg read_strobe_n_o,
  output reg write_strobe_n_o,
  output reg write_strobe_hi_n_o,
  output reg strobe_oe_o,
  output reg clk_out_o,
  input wire ext_wait_n_i,
  input wire hold_request_i,
  output reg hold_ack_n_o,
  // pin function select, 1 = bus function, 0 = general port
  output wire [7:0] upper_addr_func_o,
  output wire ale_rd_func_o,
  output wire write_lo_func_o,
  output wire write_hi_func_o,
  output wire ext_wait_func_o,
  output wire hold_func_o,
  output wire clk_func_o
);

  // bus cycle states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ALE = 3'd1;
  localparam [2:0] ST_STROBE = 3'd2;
  localparam [2:0] ST_END = 3'd3;
  localparam [2:0] ST_HOLD = 3'd4;

  // synchronisers for pins and straps
  reg [2:0] strap_s1_r, strap_s2_r;
  reg wait_s1_r, wait_s2_r, hreq_s1_r, hreq_s2_r;
  reg [DATA_W-1:0] din_s1_r, din_s2_r;
  wire single_chip = strap_s2_r[0];
  wire bus16 = strap_s2_r[1];

  // configuration registers
  reg [1:0] io_region_wait_r, high_region_wait_r, low_region_wait_r;
  reg [7:0] upper_addr_pin_port_sel_r;
  reg clk_out_en_r, ext_wait_in_en_r, bus_hold_en_r;
  reg io_region_byte_width_r, high_region_byte_width_r;
  reg low_region_byte_width_r, write_strobe_en_r;

  // bus cycle state
  reg [2:0] state_r, state_nxt;
  reg [1:0] wait_cnt_r;
  reg write_r, width8_r, single_acc_r;
  reg [ADDR_W-1:0] addr_r;
  reg [DATA_W-1:0] wdata_r;

  // straps and pins pass two flops before any logic sees them
  always @(posedge clk_i) begin
    strap_s1_r <= {ext_vec_mode2_i, bus16_i, single_chip_i};
    strap_s2_r <= strap_s1_r;
    wait_s1_r <= ext_wait_n_i;
    wait_s2_r <= wait_s1_r;
    hreq_s1_r <= hold_request_i;
    hreq_s2_r <= hreq_s1_r;
    din_s1_r <= data_i;
    din_s2_r <= din_s1_r;
  end

  // register writes; blocked entirely in single chip mode
  wire wr_ok = reg_wr_i & ~single_chip; // see RULE6
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      io_region_wait_r <= `RST_IO_REGION_WAIT; // see RULE1
      high_region_wait_r <= `RST_HIGH_REGION_WAIT; // see RULE2
      low_region_wait_r <= `RST_LOW_REGION_WAIT; // see RULE3
      upper_addr_pin_port_sel_r <= `RST_ADDR_PIN_OUTPUT_SELECT; // see RULE5
      clk_out_en_r <= `RST_CTRL_BIT;
      ext_wait_in_en_r <= `RST_CTRL_BIT;
      bus_hold_en_r <= `RST_CTRL_BIT;
      io_region_byte_width_r <= `RST_CTRL_BIT;
      write_strobe_en_r <= `RST_CTRL_BIT; // see RULE13
      low_region_byte_width_r <= `RST_CTRL_BIT;
      // strap already two flops deep, so it is a clocked sample
      high_region_byte_width_r <= strap_s2_r[2]; // see RULE12
    end else if (wr_ok && reg_addr_i == `OFS_AUTO_WAIT_SELECT) begin
      io_region_wait_r <=
        reg_wdata_i[`IO_REGION_WAIT_HI:`IO_REGION_WAIT_LO];
      high_region_wait_r <=
        reg_wdata_i[`HIGH_REGION_WAIT_HI:`HIGH_REGION_WAIT_LO];
      low_region_wait_r <=
        reg_wdata_i[`LOW_REGION_WAIT_HI:`LOW_REGION_WAIT_LO];
    end else if (wr_ok && reg_addr_i == `OFS_ADDR_PIN_OUTPUT_SELECT) begin
      upper_addr_pin_port_sel_r <= reg_wdata_i;
    end else if (wr_ok && reg_addr_i == `OFS_BUS_SIGNAL_SELECT) begin
      clk_out_en_r <= reg_wdata_i[`BIT_CLK_OUT_EN];
      ext_wait_in_en_r <= reg_wdata_i[`BIT_EXT_WAIT_IN_EN];
      bus_hold_en_r <= reg_wdata_i[`BIT_BUS_HOLD_EN];
      io_region_byte_width_r <= reg_wdata_i[`BIT_IO_REGION_BYTE_WIDTH];
      high_region_byte_width_r <= reg_wdata_i[`BIT_HIGH_REGION_BYTE_WIDTH];
      write_strobe_en_r <= reg_wdata_i[`BIT_WRITE_STROBE_EN];
      low_region_byte_width_r <= reg_wdata_i[`BIT_LOW_REGION_BYTE_WIDTH];
    end
  end

  // read answer one cycle after the strobe; config regs always read ones
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `RD_UNMAPPED;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= `RD_UNMAPPED;
    end else if (reg_addr_i == `OFS_AUTO_WAIT_SELECT ||
                 reg_addr_i == `OFS_ADDR_PIN_OUTPUT_SELECT ||
                 reg_addr_i == `OFS_BUS_SIGNAL_SELECT) begin
      reg_rdata_o <= `RD_WRITE_ONLY; // see RULE7
    end else if (reg_addr_i == `OFS_BUS_STATUS) begin
      reg_rdata_o <= {4'h0, state_r == ST_HOLD, state_r != ST_IDLE,
                      bus16, single_chip};
    end else begin
      reg_rdata_o <= `RD_UNMAPPED;
    end
  end

  // pin function selection; single chip forces every pin to port
  assign ale_rd_func_o = ~single_chip;
  assign clk_func_o = ~single_chip & clk_out_en_r; // see RULE8
  assign ext_wait_func_o = ~single_chip & ext_wait_in_en_r; // see RULE9
  assign hold_func_o = ~single_chip & bus_hold_en_r; // see RULE10
  assign write_lo_func_o = ~single_chip & write_strobe_en_r; // see RULE16
  // upper strobe exists only on a 16-bit bus
  assign write_hi_func_o = write_lo_func_o & bus16; // see RULE17

  // one selector per upper address pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_upper_pin
      assign upper_addr_func_o[gi] =
        ~single_chip & ~upper_addr_pin_port_sel_r[gi]; // see RULE4 RULE14
    end
  endgenerate

  // region decode of the incoming address
  wire in_io = acc_addr_i <= `IO_REGION_END;
  wire in_io_w = in_io && acc_addr_i >= `IO_WIDTH_START;
  wire in_high = acc_addr_i >= `HIGH_REGION_START;
  wire in_low = ~in_high && acc_addr_i >= `LOW_REGION_START;
  reg [1:0] region_wait;
  reg region_w8;
  // wait field and width chosen by region
  always @* begin
    region_wait = 2'd0;
    region_w8 = ~bus16;
    if (in_io) begin
      region_wait = io_region_wait_r; // see RULE1
      if (in_io_w) region_w8 = ~bus16 | io_region_byte_width_r; // see RULE11
    end else if (in_high) begin
      region_wait = high_region_wait_r; // see RULE2
      region_w8 = ~bus16 | high_region_byte_width_r; // see RULE12
    end else if (in_low) begin
      region_wait = low_region_wait_r; // see RULE3
      region_w8 = ~bus16 | low_region_byte_width_r; // see RULE18
    end
  end

  // external ready counts only when its function is selected
  wire ext_stall = ext_wait_func_o & ~wait_s2_r; // see RULE19
  wire hold_req = hold_func_o & hreq_s2_r;
  assign acc_ready_o = (state_r == ST_IDLE) & ~hold_req;

  // bus cycle sequencer: latch, strobe with waits, end
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (hold_req) state_nxt = ST_HOLD; // see RULE10
        else if (acc_req_i) state_nxt = single_chip ? ST_END : ST_ALE;
      end
      ST_ALE: state_nxt = ST_STROBE;
      ST_STROBE: begin
        if (wait_cnt_r == 2'd0 && !ext_stall) state_nxt = ST_END;
      end
      ST_END: state_nxt = ST_IDLE;
      ST_HOLD: begin
        if (!hold_req) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // sequencer registers and captured request
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      wait_cnt_r <= 2'd0;
      write_r <= 1'b0;
      width8_r <= 1'b0;
      single_acc_r <= 1'b0;
      addr_r <= {ADDR_W{1'b0}};
      wdata_r <= {DATA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && acc_req_i && !hold_req) begin
        write_r <= acc_write_i;
        addr_r <= acc_addr_i;
        wdata_r <= acc_wdata_i;
        width8_r <= region_w8;
        single_acc_r <= single_chip;
        wait_cnt_r <= region_wait; // see RULE20
      end else if (state_r == ST_STROBE && wait_cnt_r != 2'd0) begin
        wait_cnt_r <= wait_cnt_r - 2'd1; // see RULE1 RULE2 RULE3
      end
    end
  end

  // pin drive and answer to the core, all from flops
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_o <= {ADDR_W{1'b0}};
      addr_oe_o <= 1'b0;
      data_o <= {DATA_W{1'b0}};
      data_oe_o <= 1'b0;
      ale_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      write_strobe_hi_n_o <= 1'b1;
      strobe_oe_o <= 1'b0;
      clk_out_o <= 1'b0;
      hold_ack_n_o <= 1'b1;
      acc_done_o <= 1'b0;
      acc_rdata_o <= {DATA_W{1'b0}};
      acc_width8_o <= 1'b0;
    end else begin
      // machine cycle clock, half rate of clk_i so every edge is seen
      clk_out_o <= clk_func_o & ~clk_out_o; // see RULE8
      // bus released to the other master while held
      hold_ack_n_o <= ~(state_nxt == ST_HOLD); // see RULE10
      addr_oe_o <= ~single_chip & (state_nxt != ST_HOLD);
      strobe_oe_o <= ~single_chip & (state_nxt != ST_HOLD);
      ale_o <= (state_nxt == ST_ALE); // see RULE15
      if (state_nxt == ST_ALE) addr_o <= addr_r;
      if (state_r == ST_IDLE && acc_req_i && !hold_req) addr_o <= acc_addr_i;
      read_strobe_n_o <= ~(state_nxt == ST_STROBE && !write_r); // see RULE15
      // 8-bit width uses the low strobe only
      write_strobe_n_o <= ~(state_nxt == ST_STROBE && write_r &&
                            write_lo_func_o); // see RULE16 RULE13
      write_strobe_hi_n_o <= ~(state_nxt == ST_STROBE && write_r &&
                               write_hi_func_o && !width8_r); // see RULE15
      data_oe_o <= write_r && state_nxt == ST_STROBE;
      data_o <= wdata_r;
      acc_done_o <= (state_r == ST_END);
      acc_width8_o <= width8_r;
      // read data taken at cycle end; single chip gives no data
      if (state_r == ST_END && !write_r) begin
        acc_rdata_o <= single_acc_r ? {DATA_W{1'b0}} :
          (width8_r ? {{(DATA_W-8){1'b0}}, din_s2_r[7:0]} : din_s2_r);
      end
    end
  end

endmodule // ext_bus_ctrl
`default_nettype wire

// *** verilog/ext_bus_ctrl_defines.vh ***
// offsets, field positions, reset values and region boundaries of the external bus block
`ifndef EXT_BUS_CTRL_DEFINES_VH
`define EXT_BUS_CTRL_DEFINES_VH

// register offsets on the plain register port
`define OFS_AUTO_WAIT_SELECT 8'hA5
`define OFS_ADDR_PIN_OUTPUT_SELECT 8'hA6
`define OFS_BUS_SIGNAL_SELECT 8'hA7
`define OFS_BUS_STATUS 8'hA8

// auto_wait_select fields
`define IO_REGION_WAIT_HI 7
`define IO_REGION_WAIT_LO 6
`define HIGH_REGION_WAIT_HI 5
`define HIGH_REGION_WAIT_LO 4
`define LOW_REGION_WAIT_HI 1
`define LOW_REGION_WAIT_LO 0

// bus_signal_select fields
`define BIT_CLK_OUT_EN 7
`define BIT_EXT_WAIT_IN_EN 6
`define BIT_BUS_HOLD_EN 5
`define BIT_IO_REGION_BYTE_WIDTH 4
`define BIT_HIGH_REGION_BYTE_WIDTH 3
`define BIT_WRITE_STROBE_EN 2
`define BIT_LOW_REGION_BYTE_WIDTH 1

// reset values
`define RST_IO_REGION_WAIT 2'h0
`define RST_HIGH_REGION_WAIT 2'h3
`define RST_LOW_REGION_WAIT 2'h0
`define RST_ADDR_PIN_OUTPUT_SELECT 8'h00
`define RST_CTRL_BIT 1'b0

// read answers
`define RD_WRITE_ONLY 8'hFF
`define RD_UNMAPPED 8'h00

// region boundaries (24-bit address)
`define IO_REGION_END 24'h00_00FF
`define IO_WIDTH_START 24'h00_00C0
`define LOW_REGION_START 24'h00_2000
`define HIGH_REGION_START 24'h80_0000

`endif

// *** verification/ext_bus_ctrl_sva.sv ***
// port assertions for the external bus pin control
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctrl_sva (
  // clock, reset, straps
  input wire clk_i,
  input wire rst_n_i,
  input wire single_chip_i,
  input wire bus16_i,
  // register and access port
  input wire [7:0] reg_addr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire acc_req_i,
  input wire acc_ready_o,
  input wire acc_done_o,
  // bus pins and function selects
  input wire ale_o,
  input wire read_strobe_n_o,
  input wire write_strobe_n_o,
  input wire write_strobe_hi_n_o,
  input wire clk_out_o,
  input wire ext_wait_n_i,
  input wire hold_ack_n_o,
  input wire [7:0] upper_addr_func_o,
  input wire write_hi_func_o,
  input wire ext_wait_func_o,
  input wire hold_func_o,
  input wire clk_func_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_WO_READ_ONES:
  assert property (reg_rd_i && reg_addr_i >= 8'hA5 && reg_addr_i <= 8'hA7
    |=> reg_rdata_o == 8'hFF) else $error("select read not all ones");
  // straps pass two sync flops, so wait three cycles
  AST_SINGLE_PORTS:
  assert property (single_chip_i[*3] |-> upper_addr_func_o == 8'h00
    && !clk_func_o && !hold_func_o && !ext_wait_func_o)
    else $error("bus function left on in single chip");
  AST_SINGLE_NO_STROBE:
  assert property (single_chip_i[*3] |-> read_strobe_n_o && write_strobe_n_o
    && !ale_o) else $error("strobe seen in single chip");
  AST_CLK_TOGGLE:
  assert property (clk_func_o && $past(clk_func_o)
    |-> clk_out_o != $past(clk_out_o)) else $error("clock output stuck");
  AST_CLK_IDLE:
  assert property (!clk_func_o[*2] |-> !clk_out_o)
    else $error("clock output runs while a port");
  AST_HI_STROBE_8BIT:
  assert property (!bus16_i[*3] |-> !write_hi_func_o)
    else $error("upper strobe pin taken in 8-bit mode");
  AST_HI_NEEDS_LO:
  assert property (!write_strobe_hi_n_o |-> !write_strobe_n_o)
    else $error("upper strobe without lower strobe");
  AST_HOLD_OFF:
  assert property (!hold_func_o[*3] |-> hold_ack_n_o)
    else $error("hold acknowledged while disabled");
  AST_ALE_AFTER_REQ:
  assert property (!single_chip_i[*3] ##0 (acc_req_i && acc_ready_o)
    |=> ale_o) else $error("no latch enable after request");
  AST_READY_STRETCH:
  assert property ((ext_wait_func_o && !ext_wait_n_i && !read_strobe_n_o)[*4]
    |=> !read_strobe_n_o) else $error("ready low did not stretch");
  // main scenarios reached
  cover property (acc_done_o && ext_wait_func_o);
  cover property (!hold_ack_n_o);
  cover property (single_chip_i && acc_done_o);
endmodule // ext_bus_ctrl_sva
`default_nettype wire

// *** verification/ext_bus_mem_model.sv ***
// far-side memory: read data and a stretching ready line
`timescale 1ns/1ps
`default_nettype none
module ext_bus_mem_model (
  // bus side
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic read_strobe_n_i,
  input wire logic [3:0] stall_i,
  output logic [15:0] data_o,
  output logic wait_n_o
);
  logic [3:0] cnt_r = 4'h0;
  logic [1:0] hold_r = 2'h0;
  // ready pulled at address latch so the sync flops see it in time
  always @(posedge clk_i) begin
    if (ale_i) cnt_r <= stall_i;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    if (ale_i || !read_strobe_n_i) hold_r <= 2'h3;
    else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
  end
  assign wait_n_o = (cnt_r == 4'h0);
  // junk pattern once the hold time runs out
  assign data_o = (hold_r != 2'h0) ? 16'hA55A : 16'h5AA5;
endmodule // ext_bus_mem_model
`default_nettype wire

// *** verification/ext_bus_ctrl_tb.sv ***
// self-checking bench for the external bus pin control
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctrl_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic single_chip_i = 1'b0;
  logic bus16_i = 1'b1;
  logic ext_vec_mode2_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic acc_req_i = 1'b0;
  logic acc_write_i = 1'b0;
  logic hold_request_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [23:0] acc_addr_i = 24'h00_0000;
  logic [15:0] acc_wdata_i = 16'h1234;
  logic [3:0] stall = 4'h0;
  wire [7:0] reg_rdata_o, upper_addr_func_o;
  wire [15:0] acc_rdata_o, data_o, data_i;
  wire [23:0] addr_o;
  wire acc_ready_o, acc_done_o, acc_width8_o, addr_oe_o, data_oe_o, ale_o;
  wire read_strobe_n_o, write_strobe_n_o, write_strobe_hi_n_o, strobe_oe_o;
  wire clk_out_o, ext_wait_n_i, hold_ack_n_o, ale_rd_func_o, write_lo_func_o;
  wire write_hi_func_o, ext_wait_func_o, hold_func_o, clk_func_o;
  wire [4:0] fn = {clk_func_o, ext_wait_func_o, hold_func_o, write_lo_func_o,
    write_hi_func_o};
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  // vector-mode strap starts low, raised only for the second reset
  ext_bus_ctrl u_dut (.clk_i, .rst_n_i, .single_chip_i, .bus16_i,
    .ext_vec_mode2_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .acc_req_i, .acc_write_i, .acc_addr_i, .acc_wdata_i,
    .acc_ready_o, .acc_done_o, .acc_rdata_o, .acc_width8_o, .addr_o,
    .addr_oe_o, .data_o, .data_oe_o, .data_i, .ale_o, .read_strobe_n_o,
    .write_strobe_n_o, .write_strobe_hi_n_o, .strobe_oe_o, .clk_out_o,
    .ext_wait_n_i, .hold_request_i, .hold_ack_n_o, .upper_addr_func_o,
    .ale_rd_func_o, .write_lo_func_o, .write_hi_func_o, .ext_wait_func_o,
    .hold_func_o, .clk_func_o);
  ext_bus_mem_model u_mem (.clk_i, .ale_i(ale_o),
    .read_strobe_n_i(read_strobe_n_o), .stall_i(stall), .data_o(data_i),
    .wait_n_o(ext_wait_n_i));
  // far-side view of the last access; strobe flags cleared as each request is taken
  logic [23:0] ale_addr = 24'h00_0000;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] wr_seen = 2'b00;
  always @(posedge clk_i) begin
    if (acc_req_i) begin
      wr_seen <= 2'b00;
    end else begin
      wr_seen <= wr_seen | {~write_strobe_hi_n_o, ~write_strobe_n_o};
    end
    if (ale_o) ale_addr <= addr_o;
    if (data_oe_o) wr_data <= data_o;
  end
  always #50 clk_i = ~clk_i;
  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  // n counts edges from the taking edge to done
  task automatic acc(input logic [23:0] a, input logic w, output int k);
    repeat (2) @(posedge clk_i);
    acc_addr_i <= a;
    acc_write_i <= w;
    acc_req_i <= 1'b1;
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    k = 0;
    while (acc_done_o !== 1'b1 && k < 60) begin
      idle(1);
      k++;
    end
  endtask
  task automatic t_regs;
    chk(upper_addr_func_o, 8'hFF);
    chk(fn, 5'h00);
    wr(8'hA6, 8'h0F);
    idle(1);
    chk(upper_addr_func_o, 8'hF0);
    wr(8'hA7, 8'hE4);
    idle(1);
    chk(fn, 5'h1F);
    @(posedge clk_i);
    bus16_i <= 1'b0;
    idle(4);
    chk(fn, 5'h1E);
    @(posedge clk_i);
    bus16_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'hA5 + i[7:0], 8'hFF);
    end
    rd(8'h10, 8'h00);
    $display("register test over");
  endtask
  task automatic t_waits;
    logic [23:0] region [3] = '{24'h00_0010, 24'h80_0000, 24'h00_2000};
    acc(region[1], 1'b0, n);
    chk(24'(n), 24'h00_0006);
    acc(region[2], 1'b0, n);
    chk(24'(n), 24'h00_0003);
    for (int c = 0; c < 4; c++) begin
      wr(8'hA5, {c[1:0], c[1:0], 2'b00, c[1:0]});
      for (int r = 0; r < 3; r++) begin
        acc(region[r], 1'b0, n);
        chk(24'(n), 24'(3 + c));
      end
    end
    $display("wait test over");
  endtask
  task automatic t_width;
    wr(8'hA7, 8'h12);
    acc(24'h00_00C0, 1'b0, n);
    chk({acc_width8_o, acc_rdata_o}, 17'h1_005A);
    acc(24'h80_0000, 1'b0, n);
    chk({acc_width8_o, acc_rdata_o}, 17'h0_A55A);
    acc(24'h00_2000, 1'b1, n);
    chk(acc_width8_o, 1'b1);
    chk(wr_seen, 2'b00);
    wr(8'hA7, 8'h04);
    acc(24'h80_0000, 1'b1, n);
    chk(24'(n), 24'h00_0006);
    chk(wr_seen, 2'b11);
    chk(ale_addr, 24'h80_0000);
    chk(wr_data, 16'h1234);
    $display("width test over");
  endtask
  task automatic t_ready_hold;
    wr(8'hA7, 8'h40);
    stall <= 4'h6;
    acc(24'h80_0000, 1'b0, n);
    chk(n > 8, 1'b1);
    wr(8'hA7, 8'h20);
    stall <= 4'h0;
    hold_request_i <= 1'b1;
    idle(4);
    chk({hold_ack_n_o, addr_oe_o, acc_ready_o}, 3'h0);
    @(posedge clk_i);
    hold_request_i <= 1'b0;
    idle(4);
    chk(hold_ack_n_o, 1'b1);
    $display("ready and hold test over");
  endtask
  task automatic t_single;
    @(posedge clk_i);
    single_chip_i <= 1'b1;
    idle(4);
    chk({upper_addr_func_o, fn, ale_rd_func_o}, 14'h0000);
    wr(8'hA6, 8'h00);
    acc(24'h00_2000, 1'b0, n);
    chk(24'(n), 24'h00_0001);
    @(posedge clk_i);
    single_chip_i <= 1'b0;
    idle(4);
    chk(upper_addr_func_o, 8'hF0);
    $display("single chip test over");
  endtask
  // mid-run reset with the vector-mode strap high
  task automatic t_vec_reset;
    @(posedge clk_i);
    ext_vec_mode2_i <= 1'b1;
    rst_n_i <= 1'b0;
    idle(12);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(1);
    chk(upper_addr_func_o, 8'hFF);
    acc(24'h80_0000, 1'b0, n);
    chk(24'(n), 24'h00_0006);
    chk({acc_width8_o, acc_rdata_o}, 17'h1_005A);
    $display("vector mode reset test over");
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(1);
    t_regs();
    t_waits();
    t_width();
    t_ready_hold();
    t_single();
    t_vec_reset();
    give_verdict();
  end
endmodule // ext_bus_ctrl_tb
bind ext_bus_ctrl ext_bus_ctrl_sva u_sva (.clk_i, .rst_n_i, .single_chip_i,
  .bus16_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .acc_req_i, .acc_ready_o,
  .acc_done_o, .ale_o, .read_strobe_n_o, .write_strobe_n_o,
  .write_strobe_hi_n_o, .clk_out_o, .ext_wait_n_i, .hold_ack_n_o,
  .upper_addr_func_o, .write_hi_func_o, .ext_wait_func_o, .hold_func_o,
  .clk_func_o);
`default_nettype wire
